// ### rtl/rbw_heartbeat_watchdog.sv
// Purpose: Heartbeat timeout supervisor that trips when the level stops changing
// Assumes: hb_level comes from logic on the same clock
// Notes:   Counter saturates, so a long stall cannot wrap into a false recovery
`timescale 1ns/100ps
module rbw_heartbeat_watchdog #(
    parameter logic [rbw_pkg::CNT_W-1:0] TIMEOUT_CYC = rbw_pkg::CNT_W'(rbw_pkg::HB_TIMEOUT_CYC)
) (
    input  logic clk,
    input  logic resetn,
    input  logic hb_level,
    output logic trip_r
);

    typedef enum logic [1:0] {
        ST_RUN  = 2'b01,
        ST_TRIP = 2'b10
    } rbw_wd_state_type;

    rbw_wd_state_type             state_r;
    rbw_wd_state_type             state_nxt;
    logic [rbw_pkg::CNT_W-1:0]    cnt_r;
    logic [rbw_pkg::CNT_W-1:0]    cnt_nxt;
    logic                         hb_prev_r;
    logic                         toggle;

    assign toggle = hb_level ^ hb_prev_r;

    ////////////////////////////////////////////////////////////////////////////
    // Next counter and state
    always_comb begin
        cnt_nxt   = cnt_r;
        state_nxt = state_r;
        if (toggle) begin
            cnt_nxt = '0;
        end else if (cnt_r != TIMEOUT_CYC) begin
            cnt_nxt = cnt_r + 1'b1;
        end
        unique case (state_r)
            ST_RUN: begin
                if (!toggle && cnt_r == TIMEOUT_CYC - 1'b1) begin
                    state_nxt = ST_TRIP;
                end
            end
            ST_TRIP: begin
                if (toggle) begin
                    state_nxt = ST_RUN;
                end
            end
            default: state_nxt = ST_TRIP;                       // Illegal code fails safe
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers; comes out of reset running with a fresh count
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r     <= '0;
            state_r   <= ST_RUN;
            hb_prev_r <= 1'b0;
            trip_r    <= 1'b0;
        end else begin
            cnt_r     <= cnt_nxt;
            state_r   <= state_nxt;
            hb_prev_r <= hb_level;
            trip_r    <= (state_nxt == ST_TRIP);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_trip_at_timeout: assert property (@(posedge clk) disable iff (!resetn)
        $rose(trip_r) |-> $past(cnt_r) == TIMEOUT_CYC - 1'b1)
        else $error("watchdog tripped at the wrong count");
    a_toggle_restart: assert property (@(posedge clk) disable iff (!resetn)
        toggle |=> cnt_r == '0)
        else $error("heartbeat change did not restart the count");
    a_trip_resume: assert property (@(posedge clk) disable iff (!resetn)
        trip_r && toggle |=> !trip_r)
        else $error("trip not released on heartbeat change");
    a_trip_holds: assert property (@(posedge clk) disable iff (!resetn)
        trip_r && !toggle |=> trip_r)
        else $error("trip released without heartbeat");

endmodule

// ### rtl/rbw_pkg.sv
// Purpose: Shared constants and carrier types for the relay board output watchdog
// Assumes: 250 MHz system clock
// Notes:   Channel indices follow the bit order of the command word
package rbw_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam longint unsigned CLK_HZ         = 64'd250000000;
    localparam longint unsigned HB_TIMEOUT_S   = 64'd30;
    localparam longint unsigned HB_TIMEOUT_CYC = HB_TIMEOUT_S * CLK_HZ;
    localparam int              CNT_W          = 33;

    ////////////////////////////////////////////////////////////////////////////
    // Command word bit positions, one per indicator channel
    localparam int CMD_W                        = 16;
    localparam int CH_HEARTBEAT                 = 0;
    localparam int CH_CHAMBER_HEATER            = 1;
    localparam int CH_CONVERTER_HEATER          = 2;
    localparam int CH_SPAN_OVEN_HEATER          = 4;
    localparam int CH_ZERO_SPAN_SELECT          = 6;
    localparam int CH_SAMPLE_CAL_SELECT         = 7;
    localparam int CH_CHAMBER_BYPASS            = 8;
    localparam int CH_CONVERTER_ROUTE           = 9;
    localparam int CH_SPAN_INLET_SELECT         = 10;
    localparam int CH_SPAN_SHUTOFF              = 11;
    localparam int CH_ZERO_SHUTOFF              = 12;
    localparam logic [CMD_W-1:0] SPARE_MASK     = 16'hE028;
    localparam logic [CMD_W-1:0] CMD_RESET      = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic chamber;
        logic converter;
        logic span_oven;
    } rbw_heater_type;

    typedef struct packed {
        logic zero_span_select;
        logic sample_cal_select;
        logic chamber_bypass;
        logic converter_route;
        logic span_inlet_select;
        logic span_shutoff;
        logic zero_shutoff;
    } rbw_valve_type;

    typedef struct packed {
        logic span_gen;
        logic dual_span;
        logic press_span;
        logic press_zero;
    } rbw_option_type;

    localparam rbw_heater_type HEATER_OFF  = 3'h0;
    localparam rbw_valve_type  VALVE_OFF   = 7'h00;
    localparam rbw_option_type OPTION_NONE = 4'h0;

endpackage

// ### rtl/rbw_relay_board.sv
// Purpose: Relay board output controller with heartbeat watchdog
// Assumes: Command words arrive decoded from the serial bus on the same clock
// Notes:   Option straps are pins and pass a two-stage synchroniser
`timescale 1ns/100ps
module rbw_relay_board #(
    parameter logic [rbw_pkg::CNT_W-1:0] TIMEOUT_CYC = rbw_pkg::CNT_W'(rbw_pkg::HB_TIMEOUT_CYC)
) (
    input  logic                          clk,
    input  logic                          resetn,
    input  logic                          cmd_valid,
    input  logic [rbw_pkg::CMD_W-1:0]     cmd_data,
    input  rbw_pkg::rbw_option_type       option_pins,
    output rbw_pkg::rbw_heater_type       heater_r,
    output rbw_pkg::rbw_valve_type        valve_r,
    output logic [rbw_pkg::CMD_W-1:0]     led_r,
    output logic                          wdog_trip_r
);

    logic [rbw_pkg::CMD_W-1:0]  cmd_r;
    logic [rbw_pkg::CMD_W-1:0]  cmd_nxt;
    rbw_pkg::rbw_option_type    opt_meta_r;
    rbw_pkg::rbw_option_type    opt_r;
    rbw_pkg::rbw_heater_type    heater_nxt;
    rbw_pkg::rbw_valve_type     valve_nxt;
    logic [rbw_pkg::CMD_W-1:0]  led_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Option straps: two flops; only the second stage is read
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            opt_meta_r <= rbw_pkg::OPTION_NONE;
            opt_r      <= rbw_pkg::OPTION_NONE;
        end else begin
            opt_meta_r <= option_pins;
            opt_r      <= opt_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command latch; holds the last word until a new one is taken
    always_comb begin
        cmd_nxt = cmd_r;
        if (cmd_valid) begin
            cmd_nxt = cmd_data;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmd_r <= rbw_pkg::CMD_RESET;
        end else begin
            cmd_r <= cmd_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog on the heartbeat channel as commanded by the host
    rbw_heartbeat_watchdog #(
        .TIMEOUT_CYC (TIMEOUT_CYC)
    ) u_wdog (
        .clk      (clk),
        .resetn   (resetn),
        .hb_level (cmd_r[rbw_pkg::CH_HEARTBEAT]),
        .trip_r   (wdog_trip_r)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output decode; a trip overrides every heater and valve command so the load fails safe
    always_comb begin
        heater_nxt.chamber           = cmd_r[rbw_pkg::CH_CHAMBER_HEATER];
        heater_nxt.converter         = cmd_r[rbw_pkg::CH_CONVERTER_HEATER];
        heater_nxt.span_oven         = cmd_r[rbw_pkg::CH_SPAN_OVEN_HEATER]
                                       & opt_r.span_gen;
        valve_nxt.zero_span_select   = cmd_r[rbw_pkg::CH_ZERO_SPAN_SELECT];
        valve_nxt.sample_cal_select  = cmd_r[rbw_pkg::CH_SAMPLE_CAL_SELECT];
        valve_nxt.chamber_bypass     = cmd_r[rbw_pkg::CH_CHAMBER_BYPASS];
        valve_nxt.converter_route    = cmd_r[rbw_pkg::CH_CONVERTER_ROUTE];
        valve_nxt.span_inlet_select  = cmd_r[rbw_pkg::CH_SPAN_INLET_SELECT]
                                       & opt_r.dual_span;
        valve_nxt.span_shutoff       = cmd_r[rbw_pkg::CH_SPAN_SHUTOFF]
                                       & opt_r.press_span;
        valve_nxt.zero_shutoff       = cmd_r[rbw_pkg::CH_ZERO_SHUTOFF]
                                       & opt_r.press_zero;
        if (wdog_trip_r) begin
            heater_nxt = rbw_pkg::HEATER_OFF;
            valve_nxt  = rbw_pkg::VALVE_OFF;
        end
        // Indicators mirror what is really energized, so a trip darkens all but the heartbeat indicator
        led_nxt                                   = '0;
        led_nxt[rbw_pkg::CH_HEARTBEAT]            = cmd_r[rbw_pkg::CH_HEARTBEAT];
        led_nxt[rbw_pkg::CH_CHAMBER_HEATER]       = heater_nxt.chamber;
        led_nxt[rbw_pkg::CH_CONVERTER_HEATER]     = heater_nxt.converter;
        led_nxt[rbw_pkg::CH_SPAN_OVEN_HEATER]     = heater_nxt.span_oven;
        led_nxt[rbw_pkg::CH_ZERO_SPAN_SELECT]     = valve_nxt.zero_span_select;
        led_nxt[rbw_pkg::CH_SAMPLE_CAL_SELECT]    = valve_nxt.sample_cal_select;
        led_nxt[rbw_pkg::CH_CHAMBER_BYPASS]       = valve_nxt.chamber_bypass;
        led_nxt[rbw_pkg::CH_CONVERTER_ROUTE]      = valve_nxt.converter_route;
        led_nxt[rbw_pkg::CH_SPAN_INLET_SELECT]    = valve_nxt.span_inlet_select;
        led_nxt[rbw_pkg::CH_SPAN_SHUTOFF]         = valve_nxt.span_shutoff;
        led_nxt[rbw_pkg::CH_ZERO_SHUTOFF]         = valve_nxt.zero_shutoff;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            heater_r <= rbw_pkg::HEATER_OFF;
            valve_r  <= rbw_pkg::VALVE_OFF;
            led_r    <= '0;
        end else begin
            heater_r <= heater_nxt;
            valve_r  <= valve_nxt;
            led_r    <= led_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    // A trip darkens every heater and valve on the next edge
    a_trip_forces_off: assert property (@(posedge clk) disable iff (!resetn)
        wdog_trip_r |=> heater_r == rbw_pkg::HEATER_OFF && valve_r == rbw_pkg::VALVE_OFF)
        else $error("outputs not forced off during trip");

    // Only the heartbeat indicator may stay lit while tripped
    a_trip_leds_dark: assert property (@(posedge clk) disable iff (!resetn)
        wdog_trip_r |=> led_r[rbw_pkg::CMD_W-1:1] == '0)
        else $error("indicator lit during trip");

    // A strobed word is latched whole on its own edge
    a_cmd_latch: assert property (@(posedge clk) disable iff (!resetn)
        cmd_valid |=> cmd_r == $past(cmd_data))
        else $error("command word not latched");

    // Without a strobe the last word stays in force
    a_cmd_hold: assert property (@(posedge clk) disable iff (!resetn)
        !cmd_valid |=> $stable(cmd_r))
        else $error("command word changed without a strobe");

    // End to end: strobe, latch, then the heater output two edges on
    a_cmd_to_heater: assert property (@(posedge clk) disable iff (!resetn)
        cmd_valid ##1 !wdog_trip_r |=>
        heater_r.chamber == $past(cmd_data[rbw_pkg::CH_CHAMBER_HEATER], 2))
        else $error("chamber heater does not follow command");

    // Both fixed heaters follow their command bits
    a_heater_follow: assert property (@(posedge clk) disable iff (!resetn)
        !wdog_trip_r |=> heater_r.chamber == $past(cmd_r[rbw_pkg::CH_CHAMBER_HEATER])
        && heater_r.converter == $past(cmd_r[rbw_pkg::CH_CONVERTER_HEATER]))
        else $error("heater does not follow command");

    // Gas source selection follows the command while running
    a_gas_select: assert property (@(posedge clk) disable iff (!resetn)
        !wdog_trip_r |=> valve_r.zero_span_select == $past(cmd_r[rbw_pkg::CH_ZERO_SPAN_SELECT])
        && valve_r.sample_cal_select == $past(cmd_r[rbw_pkg::CH_SAMPLE_CAL_SELECT]))
        else $error("gas select valves do not follow command");

    // Flow routing follows the command while running
    a_flow_route: assert property (@(posedge clk) disable iff (!resetn)
        !wdog_trip_r |=> valve_r.chamber_bypass == $past(cmd_r[rbw_pkg::CH_CHAMBER_BYPASS])
        && valve_r.converter_route == $past(cmd_r[rbw_pkg::CH_CONVERTER_ROUTE]))
        else $error("flow route valves do not follow command");

    // Converter heater and zero shutoff indicators track the outputs they belong to
    a_led_mirror: assert property (@(posedge clk) disable iff (!resetn)
        led_r[rbw_pkg::CH_CONVERTER_HEATER] == heater_r.converter
        && led_r[rbw_pkg::CH_ZERO_SHUTOFF] == valve_r.zero_shutoff)
        else $error("indicator differs from its output");

    // Heartbeat indicator shows the commanded level, tripped or not
    a_led_heartbeat: assert property (@(posedge clk) disable iff (!resetn)
        led_r[rbw_pkg::CH_HEARTBEAT] == $past(cmd_r[rbw_pkg::CH_HEARTBEAT]))
        else $error("heartbeat indicator differs from command");

    // Spare positions never light, whatever the host sends
    a_spares_dark: assert property (@(posedge clk) disable iff (!resetn)
        (led_r & rbw_pkg::SPARE_MASK) == '0)
        else $error("spare indicator lit");

    // No generator, no oven heat
    a_oven_option: assert property (@(posedge clk) disable iff (!resetn)
        !opt_r.span_gen |=> !heater_r.span_oven)
        else $error("span oven heats without generator");

    // With the generator fitted the oven follows its bit
    a_oven_follow: assert property (@(posedge clk) disable iff (!resetn)
        !wdog_trip_r && opt_r.span_gen
        |=> heater_r.span_oven == $past(cmd_r[rbw_pkg::CH_SPAN_OVEN_HEATER]))
        else $error("span oven does not follow command");

    // Span option valves stay idle without their options
    a_shutoff_option: assert property (@(posedge clk) disable iff (!resetn)
        !opt_r.press_span && !opt_r.dual_span |=> !valve_r.span_shutoff
        && !valve_r.span_inlet_select)
        else $error("span option valve active without option");

    // Span inlet select follows its bit with the dual span option fitted
    a_inlet_follow: assert property (@(posedge clk) disable iff (!resetn)
        !wdog_trip_r && opt_r.dual_span
        |=> valve_r.span_inlet_select == $past(cmd_r[rbw_pkg::CH_SPAN_INLET_SELECT]))
        else $error("span inlet select does not follow command");

    // Span shutoff follows its bit with a pressurized span option fitted
    a_span_shutoff: assert property (@(posedge clk) disable iff (!resetn)
        !wdog_trip_r && opt_r.press_span
        |=> valve_r.span_shutoff == $past(cmd_r[rbw_pkg::CH_SPAN_SHUTOFF]))
        else $error("span shutoff does not follow command");

    // No pressurized zero, no zero shutoff
    a_zero_option: assert property (@(posedge clk) disable iff (!resetn)
        !opt_r.press_zero |=> !valve_r.zero_shutoff)
        else $error("zero shutoff active without option");

    // With pressurized zero fitted the zero shutoff follows its bit
    a_zero_follow: assert property (@(posedge clk) disable iff (!resetn)
        !wdog_trip_r && opt_r.press_zero
        |=> valve_r.zero_shutoff == $past(cmd_r[rbw_pkg::CH_ZERO_SHUTOFF]))
        else $error("zero shutoff does not follow command");

endmodule

// ### testbench/rbw_host_model.sv
// Purpose: Host side model that issues command words and keeps the heartbeat
// Assumes: Requests come from the bench just after a rising edge
// Notes:   An idle bus shows the inverse of the last word, never a stale copy
`timescale 1ns/100ps
module rbw_host_model (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        send,
    input  wire logic        hb_toggle,
    input  wire logic [15:0] word,
    output logic             cmd_valid,
    output logic [15:0]      cmd_data
);
    logic        hb_r;
    logic [15:0] last_r;
    ////////////////////////////////////////////////////////////////////////////
    // One word per requested cycle; heartbeat flipped only when asked
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmd_valid <= 1'b0;
            cmd_data  <= 16'hFFFF;
            hb_r      <= 1'b0;
            last_r    <= 16'h0000;
        end else if (send) begin
            cmd_valid <= 1'b1;
            cmd_data  <= {word[15:1], hb_r ^ hb_toggle};
            last_r    <= {word[15:1], hb_r ^ hb_toggle};
            hb_r      <= hb_r ^ hb_toggle;
        end else begin
            cmd_valid <= 1'b0;
            cmd_data  <= ~last_r; // Released lines must not look valid
        end
    end
endmodule

// ### testbench/rbw_relay_board_tb_top.sv
// Purpose: Self-checking bench for the relay board with a reference model
// Assumes: Short watchdog timeout so a trip fits in a brief run
// Notes:   Outputs compared a few cycles after each word, once settled
`timescale 1ns/100ps
module rbw_relay_board_tb_top;
    localparam logic [rbw_pkg::CNT_W-1:0] TMO = 33'h32;
    logic                    clk;
    logic                    resetn;
    logic                    send;
    logic                    hb_toggle;
    logic [15:0]             word;
    logic                    cmd_valid;
    logic [15:0]             cmd_data;
    rbw_pkg::rbw_option_type option_pins;
    rbw_pkg::rbw_heater_type heater_r;
    rbw_pkg::rbw_valve_type  valve_r;
    logic [15:0]             led_r;
    logic                    wdog_trip_r;
    int                      miscompares;
    int                      num_checks;
    int                      seed;
    int                      i;
    logic [15:0]             cw;
    logic [3:0]              opt;
    logic                    hb;

    rbw_relay_board #(.TIMEOUT_CYC(TMO)) i_rbw_relay_board (
        .clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
        .option_pins(option_pins), .heater_r(heater_r), .valve_r(valve_r),
        .led_r(led_r), .wdog_trip_r(wdog_trip_r));
    rbw_host_model i_rbw_host_model (
        .clk(clk), .resetn(resetn), .send(send), .hb_toggle(hb_toggle),
        .word(word), .cmd_valid(cmd_valid), .cmd_data(cmd_data));

    ////////////////////////////////////////////////////////////////////////////
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Reference: option gating, spares dark, trip keeps only the heartbeat lit
    function automatic logic [15:0] exp_led(input logic [15:0] c, input logic [3:0] o,
                                            input logic t);
        logic [15:0] m;
        m = c & 16'h1FD7;
        if (!o[3]) m[4] = 1'b0;
        if (!o[2]) m[10] = 1'b0;
        if (!o[1]) m[11] = 1'b0;
        if (!o[0]) m[12] = 1'b0;
        if (t) m = m & 16'h0001;
        return m;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic cmp(input logic t);
        logic [15:0] e;
        e = exp_led(cw, opt, t);
        check(led_r, e);
        check(16'(heater_r), {13'h0, e[1], e[2], e[4]});
        check(16'(valve_r), {9'h0, e[6], e[7], e[8], e[9], e[10], e[11], e[12]});
        check(16'(wdog_trip_r), {15'h0, t});
    endtask

    // One request through the host; bench keeps its own heartbeat copy
    task automatic put(input logic [15:0] w, input logic tg);
        @(posedge clk);
        send        <= 1'b1;
        word        <= w;
        hb_toggle   <= tg;
        option_pins <= opt;
        @(posedge clk);
        send <= 1'b0;
        if (tg) hb = ~hb;
        cw = {w[15:1], hb};
    endtask

    task automatic settle(input logic t);
        repeat (4) @(posedge clk);
        @(negedge clk);
        cmp(t);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        seed = 10; hb = 1'b0; cw = 16'h0000; opt = 4'h0;
        resetn = 1'b0; send = 1'b0; word = 16'h0000; hb_toggle = 1'b0;
        option_pins = 4'h0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        cmp(1'b0);
        @(posedge clk);
        resetn <= 1'b1;
        // Walk each channel alone, then every option strap combination
        for (i = 0; i < 16; i++) begin
            opt = 4'hF;
            put(16'h0001 << i, 1'b1);
            settle(1'b0);
        end
        for (i = 0; i < 16; i++) begin
            opt = i[3:0];
            put(16'hFFFF, 1'b1);
            settle(1'b0);
        end
        for (i = 0; i < 24; i++) begin
            opt = 4'($random(seed));
            put(16'($random(seed)), 1'b1);
            settle(1'b0);
        end
        // Back to back words: the last one wins
        @(posedge clk);
        send <= 1'b1; word <= 16'h1FFF; hb_toggle <= 1'b1;
        @(posedge clk);
        word <= 16'h0A42;
        @(posedge clk);
        send <= 1'b0;
        cw = {15'h0521, hb};
        settle(1'b0);
        // Stall the heartbeat; a word with the same level must not restart it
        put(16'h1FD6, 1'b1);
        repeat (20) @(posedge clk);
        put(16'h1FD6, 1'b0);
        repeat (18) @(posedge clk);
        @(negedge clk);
        check(16'(wdog_trip_r), 16'h0000);
        // Looked at on the falling edge, so the edge that launches the trip cannot race us
        for (i = 0; i < 20 && wdog_trip_r !== 1'b1; i++) @(negedge clk);
        if (wdog_trip_r !== 1'b1) begin
            miscompares++;
        end else begin
            // Count restarted 4 edges after the toggling request; last look was at edge 42
            check(16'(i), 16'(TMO) - 16'h0026);
            settle(1'b1);
            put(16'h1FD6, 1'b1);
            settle(1'b0);
            // Reset in mid-run clears everything at once
            @(posedge clk);
            resetn <= 1'b0;
            hb = 1'b0;
            cw = 16'h0000;
            @(negedge clk);
            cmp(1'b0);
            @(posedge clk);
            resetn <= 1'b1;
            put(16'h0F56, 1'b1);
            settle(1'b0);
        end
        conclude();
    end
endmodule
